// ---- common/adsq_pkg.sv ----
// Purpose: Shared constants and types for the ADC scan sequencer
// Assumes: core_clk at 125 MHz; registers reached over AHB-Lite
// Notes: Offsets are byte addresses; one register per aligned word
// What this block does
// - Mux and gain follow the channel pointer
// - Continuous scans step first to last, wrap
// - Halted scan keeps its pointer value
// - Every new scan reloads pointer to first
// - Results shift in on the converter clock
// - Previous result stored, new-data flag set
// - Shift and store finish within 8 us
// - Trigger-only mode drops the stale first result
// - Other modes drop the first result
// - Other modes add a flush conversion
// - Falling trigger edge starts any scan mode when enabled
// - Trigger-only: each falling edge, one conversion
// - 8-bit prescaler runs from 8 MHz tick
// - Prescaler clocks the 16-bit interval counter
// - Trigger period spans 125 ns to 2.0889 s
// - Uniform modes convert on each interval expiry
// - Burst spacing 15 us, bursts by interval
// - Interrupt per channel or per group
// - Vector given the cycle after interrupt acknowledge
// - Request released on acknowledge
// - Colliding mailbox read waits for the write
package adsq_pkg;
	localparam int CLK_MHZ = 125; // Core clock rate
	localparam int BRD_MHZ = 8; // Board tick rate
	localparam int XFER_NS = 8000; // Shift and store deadline
	localparam int BURST_NS = 15000; // Channel spacing in a burst
	// Deadline rounds down, spacing rounds up
	localparam logic [11:0] XFER_CYC = 12'(XFER_NS * CLK_MHZ / 1000);
	localparam logic [11:0] BURST_CYC = 12'((BURST_NS * CLK_MHZ + 999) / 1000);
	localparam logic [6:0] ACC_STEP = 7'(BRD_MHZ); // Phase step of tick
	localparam logic [6:0] ACC_MOD = 7'(CLK_MHZ); // Phase modulus of tick
	localparam int NCH = 32; // Mailbox depth
	localparam int RES_W = 16; // Result width
	localparam logic [4:0] RES_BITS = 5'h10; // Bits per result
	localparam int CTRL_W = 7; // Control field width
	localparam int C_DIFF = 3; // Differential input select
	localparam int C_TEXT = 4; // External trigger starts scans
	localparam int C_GRP = 5; // Interrupt per group
	localparam int C_IEN = 6; // Interrupt enable
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_VEC = 8'h04;
	localparam logic [7:0] A_PRESC = 8'h08;
	localparam logic [7:0] A_INTV = 8'h0C;
	localparam logic [7:0] A_SCH = 8'h10;
	localparam logic [7:0] A_ECH = 8'h14;
	localparam logic [7:0] A_NEW = 8'h18;
	localparam logic [7:0] A_MISS = 8'h1C;
	localparam logic [7:0] A_START = 8'h20;
	localparam logic [7:0] A_GLO = 8'h24;
	localparam logic [7:0] A_GHI = 8'h28;
	localparam logic [7:0] A_STAT = 8'h2C;
	localparam int A_MBOX_BIT = 7; // Set for mailbox window 0x80..0xFC
	typedef enum logic [2:0] {
		M_OFF = 3'h0, M_UCONT = 3'h1, M_USING = 3'h2,
		M_BCONT = 3'h3, M_BSING = 3'h4, M_ETO = 3'h5
	} adsq_mode_t;
	typedef enum logic [1:0] {S_IDLE = 2'h0, S_RUN = 2'h1, S_FLUSH = 2'h3} adsq_state_t;
endpackage

// ---- common/adsq_res_if.sv ----
// Purpose: Result path between sequencer and shift register
// Assumes: Both ends on core_clk
// Notes: arm is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface adsq_res_if;
	logic arm; // Conversion launched
	logic done; // Full result captured
	logic [adsq_pkg::RES_W-1:0] word; // Captured result
	modport seq (output arm, input done, input word);
	modport shf (input arm, output done, output word);
endinterface
`default_nettype wire

// ---- verilog/adsq_timer.sv ----
// Purpose: Board tick, prescaler and interval counter
// Assumes: run low for one cycle reloads both counters
// Notes: Period is presc times intv board ticks, zero acts as one
`timescale 1ns/1ps
`default_nettype none
module adsq_timer (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic run,
	input wire logic [7:0] presc,
	input wire logic [15:0] intv,
	output logic expire
);
	logic [6:0] acc, next_acc; // Phase accumulator for 8 MHz tick
	logic tick, next_tick; // Board tick enable
	logic [7:0] pre, next_pre; // Prescaler count
	logic [15:0] ivl, next_ivl; // Interval count
	logic next_expire;
	logic [7:0] acc_sum; // Spare top bit: the sum must not wrap before the modulus test
	// Fractional divider keeps the exact mean board rate
	always_comb begin
		acc_sum = {1'b0, acc} + {1'b0, adsq_pkg::ACC_STEP};
		next_tick = 1'b0;
		if (acc_sum >= {1'b0, adsq_pkg::ACC_MOD}) begin
			acc_sum = acc_sum - {1'b0, adsq_pkg::ACC_MOD};
			next_tick = 1'b1;
		end
		next_acc = acc_sum[6:0];
		next_pre = pre;
		next_ivl = ivl;
		next_expire = 1'b0;
		if (!run) begin
			next_pre = presc;
			next_ivl = intv;
		end else if (tick) begin
			if (pre <= 8'h01) begin
				next_pre = presc;
				if (ivl <= 16'h0001) begin
					next_ivl = intv;
					next_expire = 1'b1;
				end else begin
					next_ivl = ivl - 16'h0001;
				end
			end else begin
				next_pre = pre - 8'h01;
			end
		end
	end
	// Register stage
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			acc <= 7'h00;
			tick <= 1'b0;
			pre <= 8'h00;
			ivl <= 16'h0000;
			expire <= 1'b0;
		end else begin
			acc <= next_acc;
			tick <= next_tick;
			pre <= next_pre;
			ivl <= next_ivl;
			expire <= next_expire;
		end
	end
	a_tick_gap: assert property (@(posedge core_clk) disable iff (!rstn)
		tick |=> !tick) else $error("board tick faster than rate");
	a_expire_tick: assert property (@(posedge core_clk) disable iff (!rstn)
		expire |-> $past(tick) && $past(run)) else $error("expiry without tick");
endmodule // adsq_timer
`default_nettype wire

// ---- verilog/adsq_shift.sv ----
// Purpose: 16-bit serial capture on the converter data clock
// Assumes: Converter clock far slower than core_clk
// Notes: Pins pass three flops; an edge counts once stages agree
`timescale 1ns/1ps
`default_nettype none
module adsq_shift (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic adc_sclk,
	input wire logic adc_sdata,
	adsq_res_if.shf res
);
	logic [2:0] ck_s, dt_s; // Pin synchronisers
	logic ck_lvl, next_ck_lvl; // Accepted clock level
	logic [4:0] cnt, next_cnt; // Bits captured
	logic [15:0] sh, next_sh; // Shift register
	logic next_done;
	logic rise;
	// Edge taken only when second and third stage agree
	always_comb begin
		next_ck_lvl = (ck_s[1] == ck_s[2]) ? ck_s[2] : ck_lvl;
		rise = next_ck_lvl && !ck_lvl;
		next_cnt = cnt;
		next_sh = sh;
		next_done = 1'b0;
		if (res.arm) begin
			next_cnt = 5'h00; // New result begins
		end else if (rise && cnt != adsq_pkg::RES_BITS) begin
			next_sh = {sh[14:0], dt_s[2]};
			next_cnt = cnt + 5'h01;
			next_done = (next_cnt == adsq_pkg::RES_BITS);
		end
	end
	// Register stage
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			ck_s <= 3'h0;
			dt_s <= 3'h0;
			ck_lvl <= 1'b0;
			cnt <= adsq_pkg::RES_BITS;
			sh <= 16'h0000;
			res.done <= 1'b0;
		end else begin
			ck_s <= {ck_s[1:0], adc_sclk};
			dt_s <= {dt_s[1:0], adc_sdata};
			ck_lvl <= next_ck_lvl;
			cnt <= next_cnt;
			sh <= next_sh;
			res.done <= next_done;
		end
	end
	assign res.word = sh;
	a_done_bits: assert property (@(posedge core_clk) disable iff (!rstn)
		res.done |-> cnt == adsq_pkg::RES_BITS && $past(cnt) == 5'h0F)
		else $error("done without sixteen bits");
endmodule // adsq_shift
`default_nettype wire

// ---- verilog/adsq_top.sv ----
// Purpose: Scan sequencer, mailbox and AHB-Lite register slave
// Assumes: One 125 MHz clock, synchronous active-low reset
// Notes: Mailbox is single port; a colliding read gets one wait
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module adsq_top (
	input wire logic core_clk, // System clock
	input wire logic rstn, // Synchronous reset, active low
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic ext_trig_n, // Trigger pin, falling edge
	input wire logic adc_sclk, // Converter data clock pin
	input wire logic adc_sdata, // Converter serial data pin
	output logic adc_convert_n, // Convert strobe, low one cycle
	output logic [4:0] mux_chan, // Multiplexer channel
	output logic mux_diff, // Differential wiring
	output logic [1:0] gain_amplifier, // Gain code
	output logic irq_request_n, // Interrupt request, active low
	input wire logic int_ack, // Acknowledge cycle from carrier
	output logic [7:0] irq_vector // Vector, valid after acknowledge
);
	// Register file
	logic [6:0] ctrl, next_ctrl; // Mode, wiring, trigger, interrupt
	logic [7:0] vec, next_vec; // Service routine vector
	logic [7:0] presc, next_presc; // Prescaler reload
	logic [15:0] intv, next_intv; // Interval reload
	logic [4:0] sch, next_sch; // First channel
	logic [4:0] ech, next_ech; // Last channel
	logic [31:0] glo, next_glo; // Gains, channels 0..15
	logic [31:0] ghi, next_ghi; // Gains, channels 16..31
	logic [31:0] new_data, next_new; // Unread result per channel
	logic [31:0] missed, next_miss; // Overwritten unread result
	logic [31:0] clr_new, clr_miss; // Write-one-to-clear masks
	logic start_wr; // Software start of a scan
	// Bus slave state
	logic d_act, next_d_act; // Data phase pending
	logic d_wr, next_d_wr;
	logic [7:0] d_addr, next_d_addr;
	logic rd_stall, next_rd_stall; // Mailbox read collided
	logic [31:0] next_hrdata;
	logic acc; // Address phase taken
	// Sequencer state
	adsq_pkg::adsq_state_t state, next_state;
	adsq_pkg::adsq_mode_t mode;
	logic [4:0] ptr, next_ptr; // Channel pointer
	logic [4:0] prev_ch, next_prev_ch; // Channel in the converter
	logic prev_keep, next_prev_keep; // That result is worth storing
	logic [4:0] shift_ch, next_shift_ch; // Channel being shifted in
	logic shift_keep, next_shift_keep;
	logic xfer_on, next_xfer_on; // Transfer window open
	logic [11:0] xfer_cnt, next_xfer_cnt; // Cycles since launch
	logic [11:0] space, next_space; // Burst spacing count
	logic pass_done, next_pass_done; // Last channel launched
	logic first_go, next_first_go; // Launch at once after start
	logic launch, is_flush, scan_start, single, burst, pace;
	logic next_conv_n;
	logic [4:0] next_mux;
	logic [1:0] next_gain;
	logic [63:0] gbits;
	// Trigger synchroniser and interrupt
	logic [2:0] trg_s;
	logic trg_lvl, next_trg_lvl, ext_fall;
	logic irq_evt, next_irq_n;
	logic [7:0] next_vec_out;
	// Mailbox and result path
	logic [15:0] mbox [adsq_pkg::NCH];
	logic mb_we, tmr_exp;
	adsq_res_if res_bus ();

	adsq_timer u_timer (
		.core_clk(core_clk),
		.rstn(rstn),
		.run(state == adsq_pkg::S_RUN && !scan_start),
		.presc(presc),
		.intv(intv),
		.expire(tmr_exp)
	);

	adsq_shift u_shift (
		.core_clk(core_clk),
		.rstn(rstn),
		.adc_sclk(adc_sclk),
		.adc_sdata(adc_sdata),
		.res(res_bus.shf)
	);

	// Register read decode, shared by address phase and stall reload
	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (a[adsq_pkg::A_MBOX_BIT]) begin
			v = 32'(mbox[a[6:2]]);
		end else begin
			case (a)
			adsq_pkg::A_CTRL: v = 32'(ctrl);
			adsq_pkg::A_VEC: v = 32'(vec);
			adsq_pkg::A_PRESC: v = 32'(presc);
			adsq_pkg::A_INTV: v = 32'(intv);
			adsq_pkg::A_SCH: v = 32'(sch);
			adsq_pkg::A_ECH: v = 32'(ech);
			adsq_pkg::A_NEW: v = new_data;
			adsq_pkg::A_MISS: v = missed;
			adsq_pkg::A_GLO: v = glo;
			adsq_pkg::A_GHI: v = ghi;
			adsq_pkg::A_STAT: v = 32'({!irq_request_n, state, ptr});
			default: v = 32'h0000_0000; // Unmapped reads as zero
			endcase
		end
		return v;
	endfunction

	assign mode = adsq_pkg::adsq_mode_t'(ctrl[2:0]);
	assign gbits = {ghi, glo};
	assign acc = hsel && htrans[1] && hready;
	assign hresp = 1'b0; // Always OKAY
	assign hreadyout = !rd_stall;
	assign mb_we = res_bus.done && xfer_on && shift_keep;
	assign res_bus.arm = launch;
	assign irq_evt = mb_we && ctrl[adsq_pkg::C_IEN]
		&& (!ctrl[adsq_pkg::C_GRP] || shift_ch == ech);

	// Bus slave and register next values; writes land at data phase end
	always_comb begin
		next_ctrl = ctrl;
		next_vec = vec;
		next_presc = presc;
		next_intv = intv;
		next_sch = sch;
		next_ech = ech;
		next_glo = glo;
		next_ghi = ghi;
		clr_new = 32'h0000_0000;
		clr_miss = 32'h0000_0000;
		start_wr = 1'b0;
		if (d_act && d_wr) begin
			case (d_addr)
			adsq_pkg::A_CTRL: next_ctrl = hwdata[adsq_pkg::CTRL_W-1:0];
			adsq_pkg::A_VEC: next_vec = hwdata[7:0];
			adsq_pkg::A_PRESC: next_presc = hwdata[7:0];
			adsq_pkg::A_INTV: next_intv = hwdata[15:0];
			adsq_pkg::A_SCH: next_sch = hwdata[4:0];
			adsq_pkg::A_ECH: next_ech = hwdata[4:0];
			adsq_pkg::A_NEW: clr_new = hwdata;
			adsq_pkg::A_MISS: clr_miss = hwdata;
			adsq_pkg::A_START: start_wr = 1'b1;
			adsq_pkg::A_GLO: next_glo = hwdata;
			adsq_pkg::A_GHI: next_ghi = hwdata;
			default: ; // Read-only or unmapped: ignored
			endcase
		end
		// Hardware set wins over a software clear in the same cycle
		next_new = new_data & ~clr_new;
		next_miss = missed & ~clr_miss;
		if (mb_we) begin
			next_new[shift_ch] = 1'b1;
			if (new_data[shift_ch]) next_miss[shift_ch] = 1'b1;
		end
		next_d_act = acc ? 1'b1 : (hready ? 1'b0 : d_act);
		next_d_wr = acc ? hwrite : d_wr;
		next_d_addr = acc ? haddr[7:0] : d_addr;
		// A mailbox read beside an internal write is redone a cycle later
		next_rd_stall = acc && !hwrite && haddr[adsq_pkg::A_MBOX_BIT] && mb_we;
		if (acc && !hwrite) next_hrdata = rd_mux(haddr[7:0]);
		else if (rd_stall) next_hrdata = rd_mux(d_addr);
		else next_hrdata = hrdata;
		// Request released on acknowledge unless a new event arrives
		if (irq_evt) next_irq_n = 1'b0;
		else if (int_ack) next_irq_n = 1'b1;
		else next_irq_n = irq_request_n;
		next_vec_out = int_ack ? vec : 8'h00;
	end

	// Register stage for bus and registers
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			ctrl <= 7'h00;
			vec <= 8'h00;
			presc <= 8'h00;
			intv <= 16'h0000;
			sch <= 5'h00;
			ech <= 5'h00;
			glo <= 32'h0000_0000;
			ghi <= 32'h0000_0000;
			new_data <= 32'h0000_0000;
			missed <= 32'h0000_0000;
			d_act <= 1'b0;
			d_wr <= 1'b0;
			d_addr <= 8'h00;
			rd_stall <= 1'b0;
			hrdata <= 32'h0000_0000;
			irq_request_n <= 1'b1;
			irq_vector <= 8'h00;
		end else begin
			ctrl <= next_ctrl;
			vec <= next_vec;
			presc <= next_presc;
			intv <= next_intv;
			sch <= next_sch;
			ech <= next_ech;
			glo <= next_glo;
			ghi <= next_ghi;
			new_data <= next_new;
			missed <= next_miss;
			d_act <= next_d_act;
			d_wr <= next_d_wr;
			d_addr <= next_d_addr;
			rd_stall <= next_rd_stall;
			hrdata <= next_hrdata;
			irq_request_n <= next_irq_n;
			irq_vector <= next_vec_out;
		end
	end

	// Mailbox write; single port, so host reads yield to it
	always_ff @(posedge core_clk) begin
		if (!rstn) mbox <= '{default: 16'h0000}; // Unwritten entries read as zero
		else if (mb_we) mbox[shift_ch] <= res_bus.word;
	end

	// Sequencer next values: pacing, pointers and result bookkeeping
	always_comb begin
		next_state = state;
		next_ptr = ptr;
		next_prev_ch = prev_ch;
		next_prev_keep = prev_keep;
		next_shift_ch = shift_ch;
		next_shift_keep = shift_keep;
		next_pass_done = pass_done;
		next_first_go = first_go;
		next_space = (space != 12'h000) ? space - 12'h001 : space;
		next_xfer_on = xfer_on;
		next_xfer_cnt = xfer_on ? xfer_cnt + 12'h001 : xfer_cnt;
		next_trg_lvl = (trg_s[1] == trg_s[2]) ? trg_s[2] : trg_lvl;
		ext_fall = trg_lvl && !next_trg_lvl;
		launch = 1'b0;
		is_flush = 1'b0;
		single = (mode == adsq_pkg::M_USING) || (mode == adsq_pkg::M_BSING);
		burst = (mode == adsq_pkg::M_BCONT) || (mode == adsq_pkg::M_BSING);
		// Uniform paces on expiry; burst on spacing, then on expiry
		pace = (burst && !pass_done) ? (space == 12'h000) : tmr_exp;
		scan_start = (start_wr && mode != adsq_pkg::M_OFF)
			|| (state == adsq_pkg::S_IDLE && ext_fall && mode != adsq_pkg::M_OFF
			&& (mode == adsq_pkg::M_ETO || ctrl[adsq_pkg::C_TEXT]));
		if (xfer_on && (xfer_cnt >= adsq_pkg::XFER_CYC - 12'h001 || res_bus.done)) begin
			next_xfer_on = 1'b0; // Late result is dropped
		end
		if (scan_start) begin
			next_state = adsq_pkg::S_RUN;
			next_ptr = sch;
			next_prev_keep = 1'b0; // Converter holds stale data
			next_pass_done = 1'b0;
			// Trigger-only mode armed by software waits for an edge
			next_first_go = (mode != adsq_pkg::M_ETO) || ext_fall;
		end else begin
			case (state)
			adsq_pkg::S_RUN: begin
				if (mode == adsq_pkg::M_OFF) begin
					// Halt: pointer left as it stands
					next_state = adsq_pkg::S_FLUSH;
				end else if (first_go) begin
					launch = 1'b1;
				end else if (mode == adsq_pkg::M_ETO) begin
					launch = ext_fall;
				end else if (single && pass_done) begin
					next_state = adsq_pkg::S_FLUSH;
				end else begin
					launch = pace;
				end
			end
			adsq_pkg::S_FLUSH: begin
				// Flush only when a stored result is still in the converter
				if (!prev_keep) begin
					next_state = adsq_pkg::S_IDLE;
				end else if (space == 12'h000) begin
					launch = 1'b1;
					is_flush = 1'b1;
					next_state = adsq_pkg::S_IDLE;
				end
			end
			adsq_pkg::S_IDLE: ;
			default: next_state = adsq_pkg::S_IDLE;
			endcase
		end
		if (launch) begin
			next_first_go = 1'b0;
			next_space = adsq_pkg::BURST_CYC - 12'h001;
			next_xfer_on = 1'b1;
			next_xfer_cnt = 12'h000;
			next_shift_ch = prev_ch; // Result of previous conversion
			next_shift_keep = prev_keep;
			next_prev_ch = ptr;
			next_prev_keep = !is_flush;
			if (!is_flush) begin
				next_pass_done = (ptr == ech);
				next_ptr = (ptr == ech) ? sch : ptr + 5'h01;
			end
		end
		// Mux and gain follow the pointer as soon as it moves
		next_mux = ctrl[adsq_pkg::C_DIFF] ? {1'b0, next_ptr[3:0]} : next_ptr;
		next_gain = gbits[{next_mux, 1'b0} +: 2];
		next_conv_n = !launch;
	end

	// Register stage for sequencer and trigger synchroniser
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state <= adsq_pkg::S_IDLE;
			ptr <= 5'h00;
			prev_ch <= 5'h00;
			prev_keep <= 1'b0;
			shift_ch <= 5'h00;
			shift_keep <= 1'b0;
			pass_done <= 1'b0;
			first_go <= 1'b0;
			space <= 12'h000;
			xfer_on <= 1'b0;
			xfer_cnt <= 12'h000;
			trg_s <= 3'h7;
			trg_lvl <= 1'b1;
			adc_convert_n <= 1'b1;
			mux_chan <= 5'h00;
			mux_diff <= 1'b0;
			gain_amplifier <= 2'h0;
		end else begin
			state <= next_state;
			ptr <= next_ptr;
			prev_ch <= next_prev_ch;
			prev_keep <= next_prev_keep;
			shift_ch <= next_shift_ch;
			shift_keep <= next_shift_keep;
			pass_done <= next_pass_done;
			first_go <= next_first_go;
			space <= next_space;
			xfer_on <= next_xfer_on;
			xfer_cnt <= next_xfer_cnt;
			trg_s <= {trg_s[1:0], ext_trig_n};
			trg_lvl <= next_trg_lvl;
			adc_convert_n <= next_conv_n;
			mux_chan <= next_mux;
			mux_diff <= ctrl[adsq_pkg::C_DIFF];
			gain_amplifier <= next_gain;
		end
	end

	a_gain_sel: assert property (@(posedge core_clk) disable iff (!rstn)
		gain_amplifier == $past(gbits[{next_mux, 1'b0} +: 2])) else $error("gain not of channel");
	a_ptr_wrap: assert property (@(posedge core_clk) disable iff (!rstn)
		launch && !is_flush && !scan_start |=> ptr == ($past(ptr) == $past(ech)
		? $past(sch) : $past(ptr) + 5'h01)) else $error("pointer step wrong");
	a_ptr_hold: assert property (@(posedge core_clk) disable iff (!rstn)
		state != adsq_pkg::S_RUN && !scan_start && !launch |=> $stable(ptr))
		else $error("pointer moved while halted");
	a_scan_reload: assert property (@(posedge core_clk) disable iff (!rstn)
		scan_start |=> ptr == $past(sch) && !prev_keep) else $error("scan start no reload");
	a_drop_first: assert property (@(posedge core_clk) disable iff (!rstn)
		scan_start ##1 launch |=> !shift_keep) else $error("first result kept");
	a_store_flag: assert property (@(posedge core_clk) disable iff (!rstn)
		mb_we |=> new_data[$past(shift_ch)]) else $error("new data flag not set");
	a_xfer_bound: assert property (@(posedge core_clk) disable iff (!rstn)
		mb_we |-> xfer_cnt < adsq_pkg::XFER_CYC) else $error("store after deadline");
	a_trig_launch: assert property (@(posedge core_clk) disable iff (!rstn)
		state == adsq_pkg::S_RUN && mode == adsq_pkg::M_ETO && !scan_start && ext_fall
		|-> launch ##1 !adc_convert_n) else $error("edge did not convert");
	a_burst_gap: assert property (@(posedge core_clk) disable iff (!rstn)
		launch && burst && !first_go && !pass_done && state == adsq_pkg::S_RUN
		|-> space == 12'h000) else $error("burst spacing short");
	a_irq_drop: assert property (@(posedge core_clk) disable iff (!rstn)
		int_ack && !irq_evt |=> irq_request_n && irq_vector == $past(vec))
		else $error("request held through acknowledge");
	a_missed_set: assert property (@(posedge core_clk) disable iff (!rstn)
		mb_we && new_data[shift_ch] |=> missed[$past(shift_ch)]) else $error("missed not set");
endmodule // adsq_top
`default_nettype wire

// ---- testbench/adsq_adc_model.sv ----
// Purpose: Converter model on the far side of the serial result link
// Assumes: Launch is a one-cycle low pulse on adc_convert_n
// Notes: Each launch returns the previous word; clock idles low
`timescale 1ns/1ps
`default_nettype none
module adsq_adc_model #(
	parameter int LAG_NS = 40 // Launch to first bit, raise for a slow part
) (
	input wire logic core_clk,
	input wire logic adc_convert_n,
	input wire logic [4:0] mux_chan,
	output logic adc_sclk,
	output logic adc_sdata
);
	logic [4:0] ch_q; // Channel in front of the converter
	logic [15:0] held = 16'hBEEF; // Stale word from an earlier session
	// Freeze the channel while a launch is low
	always @(posedge core_clk) begin
		if (adc_convert_n) begin
			ch_q <= mux_chan;
		end
	end
	// Shift the previous word out MSB first on our own clock
	initial begin
		logic [15:0] w;
		adc_sclk = 1'b0;
		adc_sdata = 1'b0;
		forever begin
			@(negedge adc_convert_n);
			#1 w = held;
			held = {11'h2D0, ch_q}; // Word names its channel
			#(LAG_NS);
			for (int i = 15; i >= 0; i--) begin
				adc_sdata = w[i];
				#40 adc_sclk = 1'b1;
				#40 adc_sclk = 1'b0;
			end
			adc_sdata = ~w[0]; // Released line shows no stale level
		end
	end
endmodule // adsq_adc_model
`default_nettype wire

// ---- testbench/adsq_top_tb.sv ----
// Purpose: Self-checking bench for the scan sequencer
// Assumes: AHB-Lite single word transfers, one slave
// Notes: Expected words come from the converter model's coding
`timescale 1ns/1ps
`default_nettype none
module adsq_top_tb;
	logic core_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic ext_trig_n = 1'b1, int_ack = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
	logic [1:0] htrans = 2'h0;
	wire logic hreadyout, hresp, sclk, sdata, conv_n, mux_diff, irq_request_n;
	wire logic [31:0] hrdata;
	wire logic [4:0] mux_chan;
	wire logic [1:0] gain_amplifier;
	wire logic [7:0] irq_vector;
	int fail_count = 0, checks_done = 0;
	always #4 core_clk = ~core_clk;
	adsq_top u_dut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.ext_trig_n(ext_trig_n), .adc_sclk(sclk), .adc_sdata(sdata),
		.adc_convert_n(conv_n), .mux_chan(mux_chan), .mux_diff(mux_diff),
		.gain_amplifier(gain_amplifier), .irq_request_n(irq_request_n),
		.int_ack(int_ack), .irq_vector(irq_vector));
	adsq_adc_model u_adc (.core_clk(core_clk), .adc_convert_n(conv_n),
		.mux_chan(mux_chan), .adc_sclk(sclk), .adc_sdata(sdata));
	// Verdict and stop
	task automatic end_of_test();
		if (fail_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Bounded wait for hready high at the coming edge
	task automatic rdy();
		int n;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		if (n >= 100) begin
			fail_count++;
			end_of_test();
		end
		@(posedge core_clk);
	endtask
	// One word transfer, entered just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		q = hrdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), q, e);
	endtask
	// Wait for the request, then run an acknowledge cycle
	task automatic irq_ack();
		int n;
		n = 0;
		while (irq_request_n !== 1'b0 && n < 20000) begin
			@(posedge core_clk);
			n++;
		end
		chk("irq", {31'h0, irq_request_n}, 32'h0);
		if (irq_request_n !== 1'b0) end_of_test();
		int_ack <= 1'b1;
		@(posedge core_clk);
		int_ack <= 1'b0;
		@(negedge core_clk);
		chk("vector", {24'h0, irq_vector}, 32'h3C);
		chk("release", {31'h0, irq_request_n}, 32'h1);
		@(posedge core_clk);
	endtask
	// Falling edge held low past 500 ns, then time for shift and store
	task automatic trig();
		ext_trig_n <= 1'b0;
		repeat (63) @(posedge core_clk);
		ext_trig_n <= 1'b1;
		repeat (1000) @(posedge core_clk);
	endtask
	initial begin
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		rd(adsq_pkg::A_CTRL, 32'h0);
		bus(1'b1, 8'h3C, 32'hFFFFFFFF);
		rd(8'h3C, 32'h0);
		bus(1'b1, adsq_pkg::A_VEC, 32'h3C);
		bus(1'b1, adsq_pkg::A_PRESC, 32'h8);
		bus(1'b1, adsq_pkg::A_INTV, 32'h8);
		bus(1'b1, adsq_pkg::A_SCH, 32'h2);
		bus(1'b1, adsq_pkg::A_ECH, 32'h4);
		bus(1'b1, adsq_pkg::A_GLO, 32'hE4E4E4E4);
		bus(1'b1, adsq_pkg::A_CTRL, 32'h62);
		// Second pass overwrites unread entries
		for (int s = 0; s < 2; s++) begin
			bus(1'b1, adsq_pkg::A_START, 32'h1);
			irq_ack();
			for (int c = 1; c < 6; c++) begin
				rd(8'(8'h80 + 4 * c), (c > 1 && c < 5) ? 32'h5A00 | c : 32'h0);
			end
			rd(adsq_pkg::A_NEW, 32'h1C);
			rd(adsq_pkg::A_MISS, s ? 32'h1C : 32'h0);
		end
		chk("gain", {30'h0, gain_amplifier}, (32'hE4E4E4E4 >> (2 * mux_chan)) & 32'h3);
		bus(1'b1, adsq_pkg::A_NEW, 32'hFFFFFFFF);
		rd(adsq_pkg::A_NEW, 32'h0);
		bus(1'b1, adsq_pkg::A_SCH, 32'h7);
		bus(1'b1, adsq_pkg::A_ECH, 32'h7);
		bus(1'b1, adsq_pkg::A_CTRL, 32'h45);
		bus(1'b1, adsq_pkg::A_START, 32'h1);
		trig();
		rd(adsq_pkg::A_NEW, 32'h0);
		trig();
		rd(adsq_pkg::A_NEW, 32'h80);
		rd(8'h9C, 32'h5A07);
		irq_ack();
		// Halt, then a differential burst single started by the trigger pin
		bus(1'b1, adsq_pkg::A_CTRL, 32'h0);
		repeat (1200) @(posedge core_clk);
		bus(1'b1, adsq_pkg::A_NEW, 32'hFFFFFFFF);
		bus(1'b1, adsq_pkg::A_SCH, 32'h11);
		bus(1'b1, adsq_pkg::A_ECH, 32'h12);
		bus(1'b1, adsq_pkg::A_CTRL, 32'h7C);
		trig();
		irq_ack();
		rd(8'hC4, 32'h5A01);
		rd(8'hC8, 32'h5A02);
		rd(adsq_pkg::A_NEW, 32'h60000);
		chk("mux", {27'h0, mux_chan}, 32'h1);
		chk("diff", {31'h0, mux_diff}, 32'h1);
		end_of_test();
	end
endmodule // adsq_top_tb
`default_nettype wire
